// ### hw/cspl_pkg.sv
// Purpose: Constants for the configuration status pin logic
// Assumes: 20 MHz clock, APB with 32-bit data
// Notes:   Offsets are byte addresses
package cspl_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_EN = 8'h0c;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h10;
  localparam logic [7:0] OFF_USER = 8'h14;
  localparam logic [7:0] OFF_ADDR = 8'h18;
  // Control fields
  localparam int CTRL_SCAN_PRIM = 0;
  localparam int CTRL_WIDE_ADDR = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // Interrupt event bits
  localparam int EV_INIT_HIGH = 0;
  localparam int EV_DATA_ERR = 1;
  localparam int EV_DONE = 2;
  localparam int EV_ADDR_STEP = 3;
  localparam int EV_W = 4;
  // User pin register fields, value then enable
  localparam int USR_RDY = 0;
  localparam int USR_STROBE = 2;
  localparam int USR_PEND_HI = 4;
  localparam int USR_PEND_LO = 6;
  localparam int USR_MODE1 = 8;
  localparam int USR_TDO = 10;
  localparam int USR_W = 12;
  localparam logic [11:0] USER_RESET = 12'h000;
  // Address widths
  localparam int ADDR_W = 22;
  localparam int ADDR_NARROW_W = 18;
  // Mode encodings of the sampled mode pins
  localparam logic [2:0] MODE_MASTER_SER = 3'h0;
  localparam logic [2:0] MODE_PERIPH_SYNC = 3'h3;
  localparam logic [2:0] MODE_PERIPH_ASYNC = 3'h5;
  localparam logic [2:0] MODE_MASTER_PAR = 3'h6;
  localparam logic [2:0] MODE_SLAVE_SER = 3'h7;
  // Configuration states, one-hot
  typedef enum logic [3:0] {
    ST_WAIT   = 4'h1,
    ST_SAMPLE = 4'h2,
    ST_LOAD   = 4'h4,
    ST_USER   = 4'h8
  } cspl_state_t;
endpackage

// ### hw/cspl_top.sv
// Purpose: Special-function status and mode pin logic of a config loader
// Assumes: All inputs synchronous to ref_clk_in; APB slave, one wait state
// Notes:   Pads are split into value and output enable
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
// Contract
// RL1 - In peripheral loading, drive byte-accept status showing host may write.
// RL2 - In async peripheral mode, a selected read shows the status on D7.
// RL3 - Before init goes high, byte-accept pin is only weakly pulled up.
// RL4 - In master parallel, strobe rises before each 18 or 22 bit address step.
// RL5 - Sample three mode inputs after init goes high; they select the mode.
// RL6 - After configuration, mode 0 and 2 are inputs, mode 1 a 3-state output.
// RL7 - During configuration, weak pull-ups on all three mode pins.
// RL8 - Scan output when scan is used, else user 3-state output after config.
// RL9 - Scan input, clock and mode-select feed logic straight from the pads.
// RL10 - Without scan primitive, scan is disabled after config, pins go user.
// RL11 - Active-high pending output stays high until user I/O are active.
// RL12 - After configuration, pending, byte-accept and strobe pins become user.
// RL13 - Active-low pending output stays low until user I/O are active.
// RL14 - During configuration, drive init low on a data error.
// RL15 - All mode inputs high decode as slave serial loading.
module cspl_top (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_b_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic [31:0]      prdata_out,
  output logic             irq_out,
  // Configuration controller
  input  wire logic        program_b_in,
  input  wire logic        init_line_in,
  input  wire logic        data_err_in,
  input  wire logic        config_done_in,
  input  wire logic        byte_consumed_in,
  input  wire logic        addr_step_in,
  output logic [2:0]       config_mode_out,
  output logic [21:0]      config_addr_out,
  // Host side of peripheral loading
  input  wire logic        host_cs_in,
  input  wire logic        host_rd_in,
  input  wire logic        host_wr_in,
  output logic             d7_out,
  output logic             d7_oe_out,
  // Status pins
  output logic             init_out,
  output logic             init_oe_out,
  output logic             rdy_busy_out,
  output logic             rdy_busy_oe_out,
  output logic             addr_strobe_out,
  output logic             addr_strobe_oe_out,
  output logic             config_pending_high_out,
  output logic             config_pending_high_oe_out,
  output logic             config_pending_low_out,
  output logic             config_pending_low_oe_out,
  // Mode pins
  input  wire logic [2:0]  config_mode_sel_in,
  output logic             mode_pullup_out,
  output logic             config_mode_sel_1_out,
  output logic             config_mode_sel_1_oe_out,
  // Scan pins
  input  wire logic        scan_tdi_in,
  input  wire logic        scan_tck_in,
  input  wire logic        scan_tms_in,
  input  wire logic        scan_tdo_data_in,
  output logic             scan_tdi_out,
  output logic             scan_tck_out,
  output logic             scan_tms_out,
  output logic             scan_active_out,
  output logic             tdo_out,
  output logic             tdo_oe_out
);
  cspl_pkg::cspl_state_t state;
  cspl_pkg::cspl_state_t next_state;
  logic [1:0]             ctrl;
  logic [11:0]            user;
  logic [3:0]             irq_stat;
  logic [3:0]             irq_en;
  logic [3:0]             events;
  logic                   init_prev;
  logic                   byte_ready;
  logic                   data_err;
  logic                   step_pend;
  logic                   periph;
  logic                   async_periph;
  logic                   master_par;
  logic                   loading;
  logic                   acc;
  logic                   wr_commit;
  logic                   addr_ok;
  logic [31:0]            rd_mux;
  logic [21:0]            next_addr;

  // Mode decode of the sampled pins
  assign periph = (config_mode_out == cspl_pkg::MODE_PERIPH_SYNC) ||
                  async_periph;
  assign async_periph = config_mode_out == cspl_pkg::MODE_PERIPH_ASYNC;
  assign master_par = config_mode_out == cspl_pkg::MODE_MASTER_PAR;
  assign loading = state == cspl_pkg::ST_LOAD;

  // Configuration sequence
  always_comb begin
    next_state = state;
    case (state)
      cspl_pkg::ST_WAIT: begin
        if (init_line_in && !init_prev) begin
          next_state = cspl_pkg::ST_SAMPLE;
        end
      end
      cspl_pkg::ST_SAMPLE: next_state = cspl_pkg::ST_LOAD;
      cspl_pkg::ST_LOAD: begin
        if (config_done_in) begin
          next_state = cspl_pkg::ST_USER;
        end
      end
      cspl_pkg::ST_USER: next_state = cspl_pkg::ST_USER;
      default: next_state = cspl_pkg::ST_WAIT;
    endcase
    if (!program_b_in) begin
      next_state = cspl_pkg::ST_WAIT;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= cspl_pkg::ST_WAIT;
      init_prev <= 1'b1;
    end else begin
      state <= next_state;
      init_prev <= init_line_in;
    end
  end

  // Mode pins are caught one cycle after init rises
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      config_mode_out <= cspl_pkg::MODE_SLAVE_SER;
    end else if (state == cspl_pkg::ST_SAMPLE) begin
      config_mode_out <= config_mode_sel_in; // see RL5 see RL15
    end
  end

  // Byte-accept flag; consumption wins over a host write
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      byte_ready <= 1'b1;
    end else if (!loading) begin
      byte_ready <= 1'b1;
    end else if (byte_consumed_in) begin
      byte_ready <= 1'b1; // see RL1
    end else if (host_wr_in && host_cs_in && periph) begin
      byte_ready <= 1'b0;
    end
  end

  // Data error holds init low until reprogrammed or until loading ends
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      data_err <= 1'b0;
      init_oe_out <= 1'b0;
    end else begin
      if (!program_b_in) begin
        data_err <= 1'b0;
      end else if (loading && data_err_in) begin
        data_err <= 1'b1;
      end
      init_oe_out <= loading && (data_err || data_err_in); // see RL14
    end
  end
  assign init_out = 1'b0;

  // Address step: strobe rises first, address moves a cycle later
  assign next_addr = config_addr_out + 22'h000001;
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      step_pend <= 1'b0;
      config_addr_out <= '0;
    end else if (!loading) begin
      step_pend <= 1'b0;
      if (state == cspl_pkg::ST_WAIT) begin
        config_addr_out <= '0;
      end
    end else if (step_pend) begin
      step_pend <= 1'b0;
      config_addr_out <= ctrl[cspl_pkg::CTRL_WIDE_ADDR] ? next_addr :
        {4'h0, next_addr[cspl_pkg::ADDR_NARROW_W-1:0]}; // see RL4
    end else if (master_par && addr_step_in) begin
      step_pend <= 1'b1; // see RL4
    end
  end

  // Status pins: config role until user I/O go active
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdy_busy_out <= 1'b1;
      rdy_busy_oe_out <= 1'b0;
      addr_strobe_out <= 1'b0;
      addr_strobe_oe_out <= 1'b0;
      config_pending_high_out <= 1'b1;
      config_pending_high_oe_out <= 1'b1;
      config_pending_low_out <= 1'b0;
      config_pending_low_oe_out <= 1'b1;
    end else if (next_state == cspl_pkg::ST_USER) begin
      rdy_busy_out <= user[cspl_pkg::USR_RDY]; // see RL12
      rdy_busy_oe_out <= user[cspl_pkg::USR_RDY+1];
      addr_strobe_out <= user[cspl_pkg::USR_STROBE];
      addr_strobe_oe_out <= user[cspl_pkg::USR_STROBE+1];
      config_pending_high_out <= user[cspl_pkg::USR_PEND_HI];
      config_pending_high_oe_out <= user[cspl_pkg::USR_PEND_HI+1];
      config_pending_low_out <= user[cspl_pkg::USR_PEND_LO];
      config_pending_low_oe_out <= user[cspl_pkg::USR_PEND_LO+1];
    end else begin
      rdy_busy_out <= loading ? byte_ready : 1'b1;
      rdy_busy_oe_out <= loading && periph &&
                         (next_state == cspl_pkg::ST_LOAD); // see RL1 see RL3
      addr_strobe_out <= master_par && loading && addr_step_in &&
                         !step_pend; // see RL4
      addr_strobe_oe_out <= master_par && loading;
      config_pending_high_out <= 1'b1; // see RL11
      config_pending_high_oe_out <= 1'b1;
      config_pending_low_out <= 1'b0; // see RL13
      config_pending_low_oe_out <= 1'b1;
    end
  end

  // Host read of status on D7 in async peripheral loading
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      d7_out <= 1'b0;
      d7_oe_out <= 1'b0;
    end else begin
      d7_out <= byte_ready; // see RL2
      d7_oe_out <= loading && async_periph && host_cs_in && host_rd_in;
    end
  end

  // Mode pins: pull-ups while configuring, mode 1 user output after
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode_pullup_out <= 1'b1;
      config_mode_sel_1_out <= 1'b0;
      config_mode_sel_1_oe_out <= 1'b0;
    end else begin
      mode_pullup_out <= next_state != cspl_pkg::ST_USER; // see RL7
      config_mode_sel_1_out <= user[cspl_pkg::USR_MODE1]; // see RL6
      config_mode_sel_1_oe_out <= (next_state == cspl_pkg::ST_USER) &&
                                  user[cspl_pkg::USR_MODE1+1];
    end
  end

  // Scan inputs go straight from pads to logic
  assign scan_tdi_out = scan_tdi_in; // see RL9
  assign scan_tck_out = scan_tck_in;
  assign scan_tms_out = scan_tms_in;

  // Scan output and scan enable
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scan_active_out <= 1'b1;
      tdo_out <= 1'b0;
      tdo_oe_out <= 1'b0;
    end else begin
      scan_active_out <= ctrl[cspl_pkg::CTRL_SCAN_PRIM] ||
                         (next_state != cspl_pkg::ST_USER); // see RL10
      if (ctrl[cspl_pkg::CTRL_SCAN_PRIM] ||
          next_state != cspl_pkg::ST_USER) begin
        tdo_out <= scan_tdo_data_in; // see RL8
        tdo_oe_out <= 1'b1;
      end else begin
        tdo_out <= user[cspl_pkg::USR_TDO]; // see RL8
        tdo_oe_out <= user[cspl_pkg::USR_TDO+1];
      end
    end
  end

  // Interrupt events
  assign events[cspl_pkg::EV_INIT_HIGH] = state == cspl_pkg::ST_SAMPLE;
  assign events[cspl_pkg::EV_DATA_ERR] = loading && data_err_in;
  assign events[cspl_pkg::EV_DONE] = loading && config_done_in;
  assign events[cspl_pkg::EV_ADDR_STEP] = loading && step_pend;

  // APB: one wait state, writes land when pready is seen high
  assign acc = psel_in && penable_in;
  assign wr_commit = acc && pready_out && pwrite_in;
  always_comb begin
    rd_mux = 32'h0000_0000;
    addr_ok = 1'b1;
    case (paddr_in)
      cspl_pkg::OFF_CTRL: rd_mux[1:0] = ctrl;
      cspl_pkg::OFF_STAT: rd_mux[15:0] = {scan_tms_in, scan_tck_in,
        scan_tdi_in, config_mode_sel_in, data_err, byte_ready,
        init_line_in, state, config_mode_out};
      cspl_pkg::OFF_IRQ_STAT: rd_mux[3:0] = irq_stat;
      cspl_pkg::OFF_IRQ_EN: rd_mux[3:0] = irq_en;
      cspl_pkg::OFF_IRQ_CLR: rd_mux = 32'h0000_0000;
      cspl_pkg::OFF_USER: rd_mux[11:0] = user;
      cspl_pkg::OFF_ADDR: rd_mux[21:0] = config_addr_out;
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else begin
      pready_out <= acc && !pready_out;
      pslverr_out <= acc && !pready_out && !addr_ok;
      prdata_out <= (acc && !pready_out && !pwrite_in) ? rd_mux :
                    32'h0000_0000;
    end
  end

  // Software registers
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl <= cspl_pkg::CTRL_RESET;
      user <= cspl_pkg::USER_RESET;
      irq_en <= 4'h0;
    end else if (wr_commit) begin
      if (paddr_in == cspl_pkg::OFF_CTRL) ctrl <= pwdata_in[1:0];
      if (paddr_in == cspl_pkg::OFF_USER) user <= pwdata_in[11:0];
      if (paddr_in == cspl_pkg::OFF_IRQ_EN) irq_en <= pwdata_in[3:0];
    end
  end

  // Sticky status, a new event wins over a clear
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_stat <= 4'h0;
      irq_out <= 1'b0;
    end else begin
      if (wr_commit && paddr_in == cspl_pkg::OFF_IRQ_CLR) begin
        irq_stat <= (irq_stat & ~pwdata_in[3:0]) | events;
      end else begin
        irq_stat <= irq_stat | events;
      end
      irq_out <= |((irq_stat | events) & irq_en);
    end
  end
endmodule

// ### testbench/cspl_chk.sv
// Purpose: Assertions on the status and scan pins
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound to cspl_top after the module
`timescale 1ns/100ps
module cspl_chk (
  // Clock, reset and inputs
  input wire logic ref_clk_in, rst_b_in, init_line_in, data_err_in,
  input wire logic byte_consumed_in, addr_step_in, host_cs_in,
  input wire logic host_rd_in, host_wr_in, scan_tdi_in, scan_tck_in,
  input wire logic scan_tms_in,
  // Outputs watched
  input wire logic [2:0]  config_mode_out,
  input wire logic [21:0] config_addr_out,
  input wire logic d7_out, d7_oe_out, init_out, init_oe_out,
  input wire logic rdy_busy_out, rdy_busy_oe_out, addr_strobe_out,
  input wire logic addr_strobe_oe_out, mode_pullup_out,
  input wire logic config_pending_high_out, config_pending_high_oe_out,
  input wire logic config_pending_low_out, config_pending_low_oe_out,
  input wire logic scan_tdi_out, scan_tck_out, scan_tms_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // Peripheral loading under way
  wire logic periph_load = mode_pullup_out && rdy_busy_oe_out;
  // Address step: request, strobe with address held, then advance
  sequence s_step;
    addr_step_in && addr_strobe_oe_out && !addr_strobe_out;
  endsequence
  sequence s_advance;
    (addr_strobe_out && $stable(config_addr_out)) ##1 (!addr_strobe_out
      && config_addr_out == $past(config_addr_out) + 22'h1);
  endsequence
  sequence s_d7_read;
    host_cs_in && host_rd_in && periph_load
      && config_mode_out == cspl_pkg::MODE_PERIPH_ASYNC;
  endsequence
  a_pend_high: assert property (
    mode_pullup_out |-> config_pending_high_out && config_pending_high_oe_out)
    else $error("pending high dropped");
  a_pend_low: assert property (
    mode_pullup_out |-> !config_pending_low_out && config_pending_low_oe_out)
    else $error("pending low dropped");
  a_rdy_weak: assert property (
    !init_line_in && mode_pullup_out |-> !rdy_busy_oe_out)
    else $error("ready driven early");
  a_scan_direct: assert property (
    scan_tdi_out == scan_tdi_in && scan_tck_out == scan_tck_in
      && scan_tms_out == scan_tms_in) else $error("scan path");
  a_strobe_step: assert property (s_step |=> s_advance)
    else $error("address step");
  a_ready_clear: assert property (
    host_cs_in && host_wr_in && !byte_consumed_in && periph_load
      |=> ##1 !rdy_busy_out) else $error("ready not cleared");
  a_d7_mirror: assert property (
    s_d7_read |=> d7_oe_out && d7_out == rdy_busy_out)
    else $error("d7 status");
  a_init_error: assert property (
    data_err_in && periph_load |=> init_oe_out && !init_out)
    else $error("init not pulled low");
endmodule
bind cspl_top cspl_chk u_chk (.*);

// ### testbench/cspl_host_model.sv
// Purpose: Configuration host on the peripheral strobes
// Assumes: Ready pin seen as value and enable combined
// Notes:   Gap sets how slowly a write follows ready
`timescale 1ns/100ps
module cspl_host_model (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  // Requests from the bench
  input  wire logic       wr_req_in,
  input  wire logic       rd_req_in,
  input  wire logic [1:0] gap_in,
  input  wire logic       rdy_in,
  // Host strobes
  output logic            cs_out,
  output logic            wr_out,
  output logic            rd_out
);
  logic [1:0] wait_cnt;
  // Reads keep the device selected while asked
  assign rd_out = rd_req_in;
  assign cs_out = rd_out | wr_out;
  // One byte write, only after ready is seen for gap plus one cycles
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wait_cnt <= 2'h0;
      wr_out   <= 1'b0;
    end else if (wr_out || !(wr_req_in && rdy_in)) begin
      wait_cnt <= 2'h0;
      wr_out   <= 1'b0;
    end else if (wait_cnt == gap_in) begin
      wr_out <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule

// ### testbench/cspl_top_tb_top.sv
// Purpose: Self-checking bench for the status pin logic
// Assumes: 20 MHz clock, host model on the strobes
// Notes:   Scenario tasks judge the pins before returning
`timescale 1ns/100ps
module cspl_top_tb_top;
  // Design ports and bench state
  logic ref_clk_in, rst_b_in, psel_in, penable_in, pwrite_in, pready_out;
  logic pslverr_out, irq_out, program_b_in, init_line_in, data_err_in;
  logic config_done_in, byte_consumed_in, addr_step_in, host_cs_in;
  logic host_rd_in, host_wr_in, d7_out, d7_oe_out, init_out, init_oe_out;
  logic rdy_busy_out, rdy_busy_oe_out, addr_strobe_out, addr_strobe_oe_out;
  logic config_pending_high_out, config_pending_high_oe_out;
  logic config_pending_low_out, config_pending_low_oe_out, mode_pullup_out;
  logic config_mode_sel_1_out, config_mode_sel_1_oe_out, scan_tdi_in;
  logic scan_tck_in, scan_tms_in, scan_tdo_data_in, scan_tdi_out;
  logic scan_tck_out, scan_tms_out, scan_active_out, tdo_out, tdo_oe_out;
  logic [7:0]  paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic [2:0]  config_mode_out, config_mode_sel_in;
  logic [21:0] config_addr_out;
  logic        wr_req, rd_req, err;
  logic [1:0]  gap;
  int          n_fail, check_count, cyc;
  cspl_top DUT (.*);
  // Host on the peripheral strobes
  cspl_host_model host (.clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .wr_req_in(wr_req), .rd_req_in(rd_req), .gap_in(gap),
    .rdy_in(rdy_busy_out & rdy_busy_oe_out), .cs_out(host_cs_in),
    .wr_out(host_wr_in), .rd_out(host_rd_in));
  // Clock
  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  // Hang guard
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic test_done;
    $display("Checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  // One APB transfer held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    if (n >= 20) chk(1'b0, 1'b1);
  endtask
  // Reprogram, then raise init with the given mode pins
  task automatic cfg(input logic [2:0] m);
    program_b_in <= 1'b0;
    config_mode_sel_in <= m;
    tick(1);
    init_line_in <= 1'b0;
    tick(1);
    program_b_in <= 1'b1;
    tick(2);
    chk({rdy_busy_oe_out, mode_pullup_out}, 2'b01);
    init_line_in <= 1'b1;
    tick(4);
    chk(config_mode_out, m);
  endtask
  task automatic t_modes;
    logic [2:0] tbl [4] = '{cspl_pkg::MODE_MASTER_SER,
      cspl_pkg::MODE_PERIPH_SYNC, cspl_pkg::MODE_PERIPH_ASYNC,
      cspl_pkg::MODE_MASTER_PAR};
    apb(1'b0, cspl_pkg::OFF_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    cfg(3'h7);
    chk(config_mode_out, cspl_pkg::MODE_SLAVE_SER);
    foreach (tbl[i]) begin
      cfg(tbl[i]);
      chk(rdy_busy_oe_out, i == 1 || i == 2);
      chk(addr_strobe_oe_out, i == 3);
      config_mode_sel_in <= ~tbl[i];
      tick(2);
      chk(config_mode_out, tbl[i]);
    end
  endtask
  task automatic t_periph;
    int n;
    cfg(cspl_pkg::MODE_PERIPH_ASYNC);
    chk(rdy_busy_out, 1'b1);
    gap <= 2'h2;
    wr_req <= 1'b1;
    n = 0;
    while (rdy_busy_out !== 1'b0 && n < 20) begin
      tick(1);
      n++;
    end
    wr_req <= 1'b0;
    rd_req <= 1'b1;
    tick(2);
    chk({d7_oe_out, d7_out, rdy_busy_out}, 3'b100);
    rd_req <= 1'b0;
    byte_consumed_in <= 1'b1;
    tick(1);
    byte_consumed_in <= 1'b0;
    tick(2);
    chk(rdy_busy_out, 1'b1);
    apb(1'b1, cspl_pkg::OFF_IRQ_EN, 32'h2);
    data_err_in <= 1'b1;
    tick(1);
    data_err_in <= 1'b0;
    tick(3);
    chk({init_oe_out, irq_out}, 2'b11);
    apb(1'b1, cspl_pkg::OFF_IRQ_EN, 32'h0);
    tick(2);
    chk(irq_out, 1'b0);
    apb(1'b0, cspl_pkg::OFF_IRQ_STAT, 32'h0);
    chk(rd, 32'h3);
    apb(1'b1, cspl_pkg::OFF_IRQ_CLR, 32'hf);
    apb(1'b0, cspl_pkg::OFF_IRQ_STAT, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_par_user;
    cfg(cspl_pkg::MODE_MASTER_PAR);
    for (int k = 0; k < 2; k++) begin
      addr_step_in <= 1'b1;
      tick(1);
      addr_step_in <= 1'b0;
      tick(1);
      chk({addr_strobe_out, config_addr_out}, 32'h0040_0000 + k);
      tick(1);
      chk({addr_strobe_out, config_addr_out}, k + 1);
      tick(1);
    end
    apb(1'b0, cspl_pkg::OFF_ADDR, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, cspl_pkg::OFF_USER, 32'hfeb);
    config_done_in <= 1'b1;
    tick(3);
    chk({config_pending_high_out, config_pending_low_out}, 2'b01);
    chk({rdy_busy_out, rdy_busy_oe_out, addr_strobe_oe_out}, 3'h7);
    chk({config_mode_sel_1_out, config_mode_sel_1_oe_out}, 2'h3);
    chk({mode_pullup_out, scan_active_out}, 2'h0);
    chk({tdo_out, tdo_oe_out}, 2'h3);
    apb(1'b0, cspl_pkg::OFF_IRQ_STAT, 32'h0);
    chk(rd, 32'hd);
    apb(1'b1, cspl_pkg::OFF_CTRL, 32'h1);
    {scan_tdi_in, scan_tms_in} <= 2'h3;
    tick(3);
    chk({tdo_out, tdo_oe_out, scan_active_out}, 3'h3);
    chk({scan_tdi_out, scan_tck_out, scan_tms_out}, 3'h5);
  endtask
  // Main sequence
  initial begin
    {rst_b_in, psel_in, penable_in, pwrite_in, init_line_in} = '0;
    {data_err_in, config_done_in, byte_consumed_in, addr_step_in} = '0;
    {wr_req, rd_req, scan_tdi_in, scan_tck_in, scan_tms_in} = '0;
    {paddr_in, pwdata_in, gap, scan_tdo_data_in} = '0;
    program_b_in = 1'b1;
    config_mode_sel_in = 3'h7;
    tick(8);
    chk({config_pending_high_out, config_pending_low_out}, 2'b10);
    rst_b_in <= 1'b1;
    t_modes();
    t_periph();
    t_par_user();
    test_done();
  end
endmodule
